// file: lsr_pkg.sv
/*
  Shared definitions for the line status and ring mode register bank:
  register indices, field positions, reset values, timing counts and the
  packed carriers for the sampled line-side signals.
  Assumes a 40 MHz core clock and an APB master with 32-bit data.
*/
package lsr_pkg;

  // Register indices as numbered in the device map; byte address is four times the index.
  localparam logic [7:0] LSR_IDX_LINE_CONTROL = 8'h11;
  localparam logic [7:0] LSR_IDX_RING_MODE = 8'h12;
  localparam logic [7:0] LSR_IDX_LINE_STATUS = 8'h13;
  localparam logic [7:0] LSR_IDX_MON_RX_GAIN = 8'h14;

  // Field positions in line_control.
  localparam int LSR_CTL_BILLING_FLAG = 0;
  localparam int LSR_CTL_RX_OVL_LATCH = 1;
  localparam int LSR_CTL_BILLING_EN = 2;
  localparam int LSR_CTL_RING_VALID_EN = 3;
  localparam int LSR_CTL_CURRENT_LIMIT_SELECT_SEL = 4;
  localparam int LSR_CTL_RX_OVL_IRQ = 5;

  // Field positions in ring_mode_control and line_condition_status.
  localparam int LSR_RING_FULLWAVE = 1;
  localparam int LSR_STAT_OVERCURRENT = 0;
  localparam int LSR_STAT_DROPOUT = 1;
  localparam int LSR_STAT_LIVE_OVL = 2;

  // Reset values.
  localparam logic [7:0] LSR_RST_LINE_CONTROL = 8'h00;
  localparam logic [7:0] LSR_RST_RING_MODE = 8'h00;
  localparam logic [7:0] LSR_RST_MON_RX_GAIN = 8'h00;

  // Monitor gain: code divided by 64, that is a right shift by six.
  localparam int LSR_GAIN_SHIFT = 6;

  // Timing: core clock rate, microsecond tick and the one-shot timeout.
  localparam int LSR_CLK_HZ = 40000000;
  localparam int LSR_TICK_NS = 1000;
  localparam int LSR_TICK_CYCLES = (LSR_TICK_NS * (LSR_CLK_HZ / 1000000)) / 1000;
  localparam int LSR_ONESHOT_US = 2000;
  localparam int LSR_ONESHOT_TICKS = LSR_ONESHOT_US * 1000 / LSR_TICK_NS;

  // Number of line-side inputs carried through the synchroniser.
  localparam int LSR_PIN_COUNT = 11;

  // Line-side inputs after synchronisation.
  typedef struct packed {
    logic rx_overload;
    logic offhook_count_done;
    logic loop_current;
    logic offhook;
    logic line_side_enable;
    logic overcurrent_160;
    logic overcurrent_60;
    logic supply_disrupt;
    logic ring_halfwave;
    logic ring_fullwave;
    logic ring_crossing;
  } lsr_pins_type;

  // Ring-detect output source selection.
  typedef enum logic [1:0] {
    LSR_SRC_HALFWAVE,
    LSR_SRC_FULLWAVE,
    LSR_SRC_ENVELOPE,
    LSR_SRC_ONESHOT
  } lsr_ring_src_type;

  // One-shot state.
  typedef enum logic {
    LSR_OS_IDLE,
    LSR_OS_RUN
  } lsr_os_state_type;

endpackage

// file: lsr_pin_sync.sv
/*
  Three-flop input synchroniser for a group of asynchronous pins. A change
  is taken only once the second and third stages agree.
  Assumes one core clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module lsr_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync;

  // Bits move only where the two later stages agree, filtering a one-cycle glitch.
  always_comb begin
    next_sync = sync_out;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_sync[i] = stage3[i];
      end
    end
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= next_sync;
    end
  end

endmodule // lsr_pin_sync
`default_nettype wire

// file: lsr_line_status_regs.sv
/*
  Line status and ring mode register bank with an APB slave port. Holds the
  ring detector mode, the live line condition flags, the latched receive
  overload and billing tone state, and the monitor receive gain stage.
  Assumes the analog detectors drive asynchronous level pins and the receive
  samples arrive on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module lsr_line_status_regs
  import lsr_pkg::*;
#(
  parameter int ONESHOT_TICKS = LSR_ONESHOT_TICKS
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [9:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_overload_in,
  input wire logic offhook_count_done_in,
  input wire logic loop_current_in,
  input wire logic offhook_in,
  input wire logic line_side_enable_in,
  input wire logic overcurrent_160_in,
  input wire logic overcurrent_60_in,
  input wire logic supply_disrupt_in,
  input wire logic ring_halfwave_in,
  input wire logic ring_fullwave_in,
  input wire logic ring_crossing_in,
  input wire logic ring_envelope_in,
  input wire logic signed [15:0] rx_sample_in,
  input wire logic rx_sample_valid_in,
  output logic signed [15:0] call_progress_monitor_out,
  output logic monitor_valid_out,
  output logic ring_detect_output,
  output logic offhook_hold_out,
  output logic rx_overload_irq_flag_out
);

  lsr_pins_type pins;
  logic [LSR_PIN_COUNT-1:0] pins_raw;
  logic [LSR_PIN_COUNT-1:0] pins_sync;

  // Register state.
  logic rectifier_fullwave_select;
  logic ring_validation_enable;
  logic billing_tone_detect_enable;
  logic current_limit_select;
  logic latched_rx_overload;
  logic rx_overload_irq_flag;
  logic billing_tone_flag;
  logic [7:0] monitor_rx_gain;
  logic next_fullwave;
  logic next_ring_valid_en;
  logic next_billing_en;
  logic next_current_limit_select;
  logic next_latched_ovl;
  logic next_irq_flag;
  logic next_billing_flag;
  logic [7:0] next_gain;

  // Bus answer state.
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // Live status and ring path state.
  logic live_overload_flag;
  logic line_dropout_flag;
  logic overcurrent_flag;
  logic next_live_ovl;
  logic next_dropout;
  logic next_overcurrent;
  logic next_ring_out;
  logic next_hold;
  lsr_ring_src_type ring_src;
  lsr_os_state_type os_state;
  lsr_os_state_type next_os_state;
  logic crossing_d;
  logic [5:0] tick_count;
  logic [5:0] next_tick_count;
  logic tick;
  logic next_tick;
  logic [15:0] os_count;
  logic [15:0] next_os_count;

  // Monitor gain path state.
  logic signed [24:0] product;
  logic signed [24:0] scaled;
  logic signed [15:0] next_monitor;
  logic next_monitor_valid;

  // Access decode.
  logic access;
  logic wr_en;
  logic [7:0] reg_idx;
  logic idx_ok;
  logic [7:0] wbyte;

  assign pins_raw = {rx_overload_in, offhook_count_done_in, loop_current_in, offhook_in,
                     line_side_enable_in, overcurrent_160_in, overcurrent_60_in,
                     supply_disrupt_in, ring_halfwave_in, ring_fullwave_in, ring_crossing_in};
  assign pins = lsr_pins_type'(pins_sync);

  // All analog detector levels cross into the core clock here.
  lsr_pin_sync #(
    .WIDTH(LSR_PIN_COUNT)
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // Envelope comes from the validation logic on this clock, so it is not synchronised.
  assign access = psel_in && penable_in && !pready_out;
  assign reg_idx = paddr_in[9:2];
  assign idx_ok = (paddr_in[1:0] == 2'b00) &&
                  ((reg_idx == LSR_IDX_LINE_CONTROL) || (reg_idx == LSR_IDX_RING_MODE) ||
                   (reg_idx == LSR_IDX_LINE_STATUS) || (reg_idx == LSR_IDX_MON_RX_GAIN));
  assign wr_en = access && pwrite_in && idx_ok && pstrb_in[0];
  assign wbyte = pwdata_in[7:0];

  // Bus answer: one wait state, so pready rises in the second access cycle.
  always_comb begin
    next_pready = access;
    next_pslverr = access && !idx_ok;
    next_prdata = prdata_out;
    if (access && !pwrite_in) begin
      next_prdata = 32'h0000_0000;
      case (reg_idx)
        LSR_IDX_LINE_CONTROL: begin
          next_prdata[LSR_CTL_BILLING_FLAG] = billing_tone_flag;
          next_prdata[LSR_CTL_RX_OVL_LATCH] = latched_rx_overload;
          next_prdata[LSR_CTL_BILLING_EN] = billing_tone_detect_enable;
          next_prdata[LSR_CTL_RING_VALID_EN] = ring_validation_enable;
          next_prdata[LSR_CTL_CURRENT_LIMIT_SELECT_SEL] = current_limit_select;
          next_prdata[LSR_CTL_RX_OVL_IRQ] = rx_overload_irq_flag;
        end
        LSR_IDX_RING_MODE: begin
          next_prdata[LSR_RING_FULLWAVE] = rectifier_fullwave_select;
        end
        LSR_IDX_LINE_STATUS: begin
          next_prdata[LSR_STAT_OVERCURRENT] = overcurrent_flag;
          next_prdata[LSR_STAT_DROPOUT] = line_dropout_flag;
          next_prdata[LSR_STAT_LIVE_OVL] = live_overload_flag;
        end
        LSR_IDX_MON_RX_GAIN: begin
          next_prdata[7:0] = monitor_rx_gain;
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register writes; hardware sets win over a software clear in the same cycle.
  always_comb begin
    next_fullwave = rectifier_fullwave_select;
    next_ring_valid_en = ring_validation_enable;
    next_billing_en = billing_tone_detect_enable;
    next_current_limit_select = current_limit_select;
    next_gain = monitor_rx_gain;
    next_latched_ovl = latched_rx_overload;
    next_irq_flag = rx_overload_irq_flag;
    next_billing_flag = billing_tone_flag;
    if (wr_en) begin
      case (reg_idx)
        LSR_IDX_LINE_CONTROL: begin
          next_billing_en = wbyte[LSR_CTL_BILLING_EN];
          next_ring_valid_en = wbyte[LSR_CTL_RING_VALID_EN];
          next_current_limit_select = wbyte[LSR_CTL_CURRENT_LIMIT_SELECT_SEL];
          if (!wbyte[LSR_CTL_RX_OVL_LATCH]) begin
            next_latched_ovl = 1'b0;
            next_irq_flag = 1'b0;
          end
          if (!wbyte[LSR_CTL_BILLING_EN]) begin
            next_billing_flag = 1'b0;
          end
        end
        LSR_IDX_RING_MODE: begin
          next_fullwave = wbyte[LSR_RING_FULLWAVE]; // Other bits are dropped.
        end
        LSR_IDX_MON_RX_GAIN: begin
          next_gain = wbyte;
        end
        default: begin
          next_gain = monitor_rx_gain;
        end
      endcase
    end
    // The latched bit uses the same masked detection as the live flag.
    if (pins.rx_overload && pins.offhook_count_done) begin
      next_latched_ovl = 1'b1;
      next_irq_flag = 1'b1;
    end
    // Only a disruption seen while detection is enabled and off-hook is flagged.
    if (billing_tone_detect_enable && pins.offhook && pins.supply_disrupt) begin
      next_billing_flag = 1'b1;
    end
  end

  // Live flags follow their causes and need no clear from software.
  always_comb begin
    next_live_ovl = pins.rx_overload && pins.offhook_count_done;
    next_dropout = !pins.loop_current ||
                   (!pins.offhook && pins.line_side_enable);
    next_overcurrent = current_limit_select ? pins.overcurrent_60 :
                                              pins.overcurrent_160;
    next_hold = billing_tone_detect_enable && pins.offhook && pins.supply_disrupt;
  end

  // Ring-detect source: validation enable picks the pair, the select bit the member.
  always_comb begin
    if (!ring_validation_enable) begin
      ring_src = rectifier_fullwave_select ? LSR_SRC_FULLWAVE : LSR_SRC_HALFWAVE;
    end else begin
      ring_src = rectifier_fullwave_select ? LSR_SRC_ONESHOT : LSR_SRC_ENVELOPE;
    end
  end

  // Microsecond tick divider keeps the one-shot counter narrow.
  always_comb begin
    next_tick = 1'b0;
    if (tick_count == 6'(LSR_TICK_CYCLES - 1)) begin
      next_tick_count = 6'h00;
      next_tick = 1'b1;
    end else begin
      next_tick_count = tick_count + 6'h01;
    end
  end

  // One-shot: a rising synchronised crossing starts it, a fixed tick count ends it.
  always_comb begin
    next_os_state = os_state;
    next_os_count = os_count;
    case (os_state)
      LSR_OS_IDLE: begin
        next_os_count = 16'h0000;
        if (pins.ring_crossing && !crossing_d) begin
          next_os_state = LSR_OS_RUN;
        end
      end
      LSR_OS_RUN: begin
        if (tick) begin
          if (os_count == 16'(ONESHOT_TICKS - 1)) begin
            next_os_state = LSR_OS_IDLE;
          end else begin
            next_os_count = os_count + 16'h0001;
          end
        end
      end
      default: begin
        next_os_state = LSR_OS_IDLE;
      end
    endcase
    case (ring_src)
      LSR_SRC_HALFWAVE: next_ring_out = pins.ring_halfwave;
      LSR_SRC_FULLWAVE: next_ring_out = pins.ring_fullwave;
      LSR_SRC_ENVELOPE: next_ring_out = ring_envelope_in;
      LSR_SRC_ONESHOT: next_ring_out = (os_state == LSR_OS_RUN);
      default: next_ring_out = 1'b0;
    endcase
  end

  // Monitor gain: sample times code over 64, saturated; code zero yields silence.
  always_comb begin
    product = 25'(rx_sample_in) * $signed({1'b0, monitor_rx_gain});
    scaled = product >>> LSR_GAIN_SHIFT;
    if (monitor_rx_gain == 8'h00) begin
      next_monitor = 16'sh0000;
    end else if (scaled > 25'sh0007fff) begin
      next_monitor = 16'sh7fff;
    end else if (scaled < -25'sh0008000) begin
      next_monitor = -16'sh8000;
    end else begin
      next_monitor = scaled[15:0];
    end
    if (!rx_sample_valid_in) begin
      next_monitor = call_progress_monitor_out;
    end
    next_monitor_valid = rx_sample_valid_in;
  end

  // All state registers; every output comes from one of these flops.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rectifier_fullwave_select <= LSR_RST_RING_MODE[LSR_RING_FULLWAVE];
      ring_validation_enable <= LSR_RST_LINE_CONTROL[LSR_CTL_RING_VALID_EN];
      billing_tone_detect_enable <= LSR_RST_LINE_CONTROL[LSR_CTL_BILLING_EN];
      current_limit_select <= LSR_RST_LINE_CONTROL[LSR_CTL_CURRENT_LIMIT_SELECT_SEL];
      latched_rx_overload <= LSR_RST_LINE_CONTROL[LSR_CTL_RX_OVL_LATCH];
      rx_overload_irq_flag <= LSR_RST_LINE_CONTROL[LSR_CTL_RX_OVL_IRQ];
      billing_tone_flag <= LSR_RST_LINE_CONTROL[LSR_CTL_BILLING_FLAG];
      monitor_rx_gain <= LSR_RST_MON_RX_GAIN;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      live_overload_flag <= 1'b0;
      line_dropout_flag <= 1'b0;
      overcurrent_flag <= 1'b0;
      ring_detect_output <= 1'b0;
      offhook_hold_out <= 1'b0;
      rx_overload_irq_flag_out <= 1'b0;
      os_state <= LSR_OS_IDLE;
      os_count <= 16'h0000;
      crossing_d <= 1'b0;
      tick_count <= 6'h00;
      tick <= 1'b0;
      call_progress_monitor_out <= 16'sh0000;
      monitor_valid_out <= 1'b0;
    end else begin
      rectifier_fullwave_select <= next_fullwave;
      ring_validation_enable <= next_ring_valid_en;
      billing_tone_detect_enable <= next_billing_en;
      current_limit_select <= next_current_limit_select;
      latched_rx_overload <= next_latched_ovl;
      rx_overload_irq_flag <= next_irq_flag;
      billing_tone_flag <= next_billing_flag;
      monitor_rx_gain <= next_gain;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      live_overload_flag <= next_live_ovl;
      line_dropout_flag <= next_dropout;
      overcurrent_flag <= next_overcurrent;
      ring_detect_output <= next_ring_out;
      offhook_hold_out <= next_hold;
      rx_overload_irq_flag_out <= next_irq_flag;
      os_state <= next_os_state;
      os_count <= next_os_count;
      crossing_d <= pins.ring_crossing;
      tick_count <= next_tick_count;
      tick <= next_tick;
      call_progress_monitor_out <= next_monitor;
      monitor_valid_out <= next_monitor_valid;
    end
  end

endmodule // lsr_line_status_regs
`default_nettype wire

// file: lsr_regs_chk.sv
/*
  Checker for the line status register bank: APB answer timing, address
  refusal, reserved read bits and the monitor receive path.
  Assumes it is bound to the bank's top module and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module lsr_regs_chk (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [9:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic rx_sample_valid_in,
  input wire logic monitor_valid_out,
  input wire logic signed [15:0] call_progress_monitor_out
);
  logic bad_addr;
  logic take;
  logic rd_done;

  // Only the four aligned words of the map are accepted; the rest are refused.
  assign bad_addr = (paddr_in[1:0] != 2'b00) || (paddr_in[9:2] < 8'h11) ||
    (paddr_in[9:2] > 8'h14);
  assign take = psel_in && penable_in && !pready_out;
  assign rd_done = pready_out && !pwrite_in;

  // All checks share the one core clock and its reset.
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_ready_one_wait: assert property (take |=> pready_out)
    else $error("pready missing after the access cycle");
  a_ready_has_cause: assert property (pready_out |-> $past(take))
    else $error("pready without a pending access");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_err_decode: assert property (take |=> (pslverr_out == $past(bad_addr)))
    else $error("pslverr does not match the address decode");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr outside the answer cycle");
  a_rdata_upper: assert property (rd_done |-> (prdata_out[31:8] == 24'h000000))
    else $error("read data upper bits not zero");
  a_ring_resv_zero: assert property ((rd_done && paddr_in == 10'h048) |->
    (prdata_out[7:2] == 6'h00 && !prdata_out[0]))
    else $error("ring mode reserved bits not zero");
  a_stat_resv_zero: assert property ((rd_done && paddr_in == 10'h04c) |->
    (prdata_out[7:3] == 5'h00))
    else $error("status reserved bits not zero");
  a_mon_follows: assert property (rx_sample_valid_in |=> monitor_valid_out)
    else $error("monitor valid missing after a sample");
  a_mon_cause: assert property (monitor_valid_out |-> $past(rx_sample_valid_in))
    else $error("monitor valid without a sample");
  a_mon_held: assert property (!rx_sample_valid_in |=> $stable(call_progress_monitor_out))
    else $error("monitor output moved between samples");

  // Main scenarios that the bench is expected to reach.
  c_write: cover property (pready_out && pwrite_in && !pslverr_out);
  c_refused: cover property (pready_out && pslverr_out);
  c_monitor: cover property (monitor_valid_out && call_progress_monitor_out != 16'sh0000);
endmodule // lsr_regs_chk
`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench for the line status register bank.
  Assumes the package, the design and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import lsr_pkg::*;
;
  localparam logic [9:0] A_CTL = {LSR_IDX_LINE_CONTROL, 2'b00};
  localparam logic [9:0] A_RING = {LSR_IDX_RING_MODE, 2'b00};
  localparam logic [9:0] A_STAT = {LSR_IDX_LINE_STATUS, 2'b00};
  localparam logic [9:0] A_GAIN = {LSR_IDX_MON_RX_GAIN, 2'b00};
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [9:0] paddr_in = 10'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, er;
  logic [3:0] pstrb_in = 4'hf;
  logic rx_overload_in = 1'b0, offhook_count_done_in = 1'b0, loop_current_in = 1'b1;
  logic offhook_in = 1'b1, line_side_enable_in = 1'b1, supply_disrupt_in = 1'b0;
  logic overcurrent_160_in = 1'b0, overcurrent_60_in = 1'b0, ring_envelope_in = 1'b0;
  logic ring_halfwave_in = 1'b0, ring_fullwave_in = 1'b0, ring_crossing_in = 1'b0;
  logic signed [15:0] rx_sample_in = 16'sh0000, call_progress_monitor_out;
  logic rx_sample_valid_in = 1'b0, monitor_valid_out, ring_detect_output;
  logic offhook_hold_out, rx_overload_irq_flag_out;
  logic [7:0] gains [6] = '{8'hff, 8'h7f, 8'h40, 8'h20, 8'h10, 8'h00};
  int n_mismatch = 0;
  int check_count = 0;

  // The one-shot is shortened to three ticks so that it ends within the run.
  lsr_line_status_regs #(.ONESHOT_TICKS(3)) dut_u (
    .core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .rx_overload_in,
    .offhook_count_done_in, .loop_current_in, .offhook_in, .line_side_enable_in,
    .overcurrent_160_in, .overcurrent_60_in, .supply_disrupt_in, .ring_halfwave_in,
    .ring_fullwave_in, .ring_crossing_in, .ring_envelope_in, .rx_sample_in,
    .rx_sample_valid_in, .call_progress_monitor_out, .monitor_valid_out,
    .ring_detect_output, .offhook_hold_out, .rx_overload_irq_flag_out);

  // Free-running 40 MHz core clock.
  always #12.5 core_clk_in = ~core_clk_in;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    chk("pready", {31'h0, pready_out}, 32'h1);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    chk("write err", {31'h0, er}, 32'h0);
  endtask

  task automatic rdc(input string what, input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, rd, {24'h0, e});
    chk("read err", {31'h0, er}, 32'h0);
  endtask

  // Expected monitor value is the floored product over 64, saturated to 16 bits.
  task automatic mon(input logic signed [15:0] s, input logic [7:0] g);
    int p;
    p = (int'(s) * int'(g)) >>> 6;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    wr(A_GAIN, g);
    rdc("gain", A_GAIN, g);
    @(posedge core_clk_in);
    rx_sample_in <= s;
    rx_sample_valid_in <= 1'b1;
    @(posedge core_clk_in);
    rx_sample_valid_in <= 1'b0;
    @(posedge core_clk_in);
    chk("mon_valid", {31'h0, monitor_valid_out}, 32'h1);
    chk("mon_out", {16'h0, call_progress_monitor_out}, {16'h0, p[15:0]});
  endtask

  task automatic ring(input logic e);
    tk(8);
    chk("ring_detect", {31'h0, ring_detect_output}, {31'h0, e});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang anywhere ends the run as a failure.
  initial begin
    tk(20000);
    n_mismatch++;
    $display("CHECK FAILED watchdog expected end seen hang");
    wrap_up();
  end

  // Main sequence: registers, ring modes, status flags, monitor gain.
  initial begin
    tk(5);
    rst_in <= 1'b0;
    tk(8);
    rdc("ctl", A_CTL, 8'h00);
    rdc("ring_mode", A_RING, 8'h00);
    rdc("status", A_STAT, 8'h00);
    rdc("gain", A_GAIN, 8'h00);
    // With the low byte strobe off, a write must leave the register alone.
    pstrb_in <= 4'he;
    wr(A_GAIN, 8'h55);
    rdc("strobe off gain", A_GAIN, 8'h00);
    pstrb_in <= 4'hf;
    apb(1'b0, 10'h058, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b1, 10'h049, 32'hff);
    chk("misaligned err", {31'h0, er}, 32'h1);
    rdc("ring_mode", A_RING, 8'h00);
    wr(A_RING, 8'hff);
    rdc("ring_mode", A_RING, 8'h02);
    $display("test registers done");
    ring_fullwave_in <= 1'b1;
    ring(1'b1);
    wr(A_RING, 8'h00);
    ring(1'b0);
    ring_halfwave_in <= 1'b1;
    ring_fullwave_in <= 1'b0;
    ring(1'b1);
    wr(A_CTL, 8'h08);
    ring(1'b0);
    ring_envelope_in <= 1'b1;
    ring(1'b1);
    wr(A_RING, 8'h02);
    ring(1'b0);
    ring_crossing_in <= 1'b1;
    tk(4);
    ring_crossing_in <= 1'b0;
    ring(1'b1);
    tk(200);
    ring(1'b0);
    wr(A_CTL, 8'h00);
    $display("test ring done");
    rx_overload_in <= 1'b1;
    tk(8);
    rdc("status", A_STAT, 8'h00);
    offhook_count_done_in <= 1'b1;
    tk(8);
    rdc("status", A_STAT, 8'h04);
    rdc("ctl", A_CTL, 8'h22);
    chk("irq", {31'h0, rx_overload_irq_flag_out}, 32'h1);
    wr(A_CTL, 8'h04);
    rdc("status", A_STAT, 8'h04);
    rx_overload_in <= 1'b0;
    tk(8);
    rdc("status", A_STAT, 8'h00);
    rdc("ctl", A_CTL, 8'h26);
    wr(A_CTL, 8'h00);
    rdc("ctl", A_CTL, 8'h00);
    chk("irq", {31'h0, rx_overload_irq_flag_out}, 32'h0);
    wr(A_CTL, 8'h04);
    supply_disrupt_in <= 1'b1;
    tk(8);
    rdc("ctl", A_CTL, 8'h05);
    chk("hold", {31'h0, offhook_hold_out}, 32'h1);
    supply_disrupt_in <= 1'b0;
    tk(8);
    chk("hold", {31'h0, offhook_hold_out}, 32'h0);
    rdc("ctl", A_CTL, 8'h05);
    wr(A_CTL, 8'h00);
    rdc("ctl", A_CTL, 8'h00);
    loop_current_in <= 1'b0;
    tk(8);
    rdc("status", A_STAT, 8'h02);
    loop_current_in <= 1'b1;
    offhook_in <= 1'b0;
    tk(8);
    rdc("status", A_STAT, 8'h02);
    line_side_enable_in <= 1'b0;
    tk(8);
    rdc("status", A_STAT, 8'h00);
    offhook_in <= 1'b1;
    line_side_enable_in <= 1'b1;
    overcurrent_160_in <= 1'b1;
    tk(8);
    rdc("status", A_STAT, 8'h01);
    wr(A_CTL, 8'h10);
    tk(2);
    rdc("status", A_STAT, 8'h00);
    overcurrent_60_in <= 1'b1;
    overcurrent_160_in <= 1'b0;
    tk(8);
    rdc("status", A_STAT, 8'h01);
    wr(A_CTL, 8'h00);
    tk(2);
    rdc("status", A_STAT, 8'h00);
    $display("test status done");
    foreach (gains[i]) begin
      mon(16'sd1000, gains[i]);
      mon(-16'sd1000, gains[i]);
    end
    mon(16'sh7fff, 8'hff);
    mon(16'sh8000, 8'hff);
    $display("test monitor done");
    wrap_up();
  end
endmodule // tb_top

// The checker watches the bank's own ports.
bind lsr_line_status_regs lsr_regs_chk chk_u (
  .core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
  .pready_out, .pslverr_out, .rx_sample_valid_in, .monitor_valid_out,
  .call_progress_monitor_out);
`default_nettype wire
